/* hw/adc_seq_params.svh */
// Constants for the converter sequencer and its serial port.
// Assumes it is included by the type package and the design module only.
`ifndef ADC_SEQ_PARAMS_SVH
`define ADC_SEQ_PARAMS_SVH

// Result and word widths.
`define ADC_CODE_BITS 24
`define ADC_WORD_BITS 32
`define ADC_HOLD_BITS 33
`define ADC_CODE_ZERO 24'h000000
`define ADC_CODE_ONES 24'hFFFFFF
`define ADC_CODE_MID 24'h800000
`define ADC_CODE_POS_MAX 24'h7FFFFF

// Conversion sources: eight inputs, then temperature sensor and input short.
`define ADC_NUM_SRC 10
`define ADC_LAST_SRC 4'h9
`define ADC_SRC_NONE 10'h000

// Filter output words per channel before a result is valid (sinc4, no chop).
`define ADC_SETTLE_WORDS 3'h4

// Serial port.
`define ADC_IFRST_ONES 6'h28
`define ADC_CMD_CREAD_ENTER 8'h5C
`define ADC_CMD_CREAD_EXIT 8'h58
`define ADC_COMM_WEN 7
`define ADC_COMM_READ 6
`define ADC_COMM_ADDR_HI 5
`define ADC_COMM_ADDR_LO 3
`define ADC_COMM_CREAD 2
`define ADC_CMD_LAST_BIT 6'h07

// Register addresses carried by the command byte.
`define ADC_REG_STATUS 3'h0
`define ADC_REG_DATA 3'h3
`define ADC_REG_ID 3'h4
`define ADC_REG_GPIO_CTRL 3'h5

// Register lengths in serial bits.
`define ADC_LEN_BYTE 6'h08
`define ADC_LEN_CODE 6'h18

// Reset values.
`define ADC_RDY_N_RST 1'b1
`define ADC_CHAN_RST 4'h0

`endif

/* hw/adc_seq_pkg.sv */
// Types for the converter sequencer: state encodings and the state records.
// Assumes adc_seq_params.svh is on the include path.
`include "adc_seq_params.svh"

package adc_seq_pkg;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b000,
    SEQ_RESET = 3'b001,
    SEQ_SETTLE = 3'b010,
    SEQ_WARN = 3'b011
  } seq_state_e;

  typedef enum logic [1:0] {
    LK_CMD = 2'b00,
    LK_WR = 2'b01,
    LK_RD = 2'b10
  } link_phase_e;

  // Core clock domain.
  typedef struct packed {
    seq_state_e state;
    logic [3:0] chan;
    logic [2:0] settle;
    logic [`ADC_CODE_BITS-1:0] code;
    logic rdy_n;
    logic [`ADC_WORD_BITS-1:0] data;
    logic [`ADC_HOLD_BITS-1:0] hold;
    logic req;
    logic dirty;
    logic mod_reset;
    logic burnout;
    logic pseudo;
    logic reference_missing_s1;
    logic reference_missing_s2;
    logic ack_s1;
    logic ack_s2;
    logic done_s1;
    logic done_s2;
    logic done_last;
    logic ifr_s1;
    logic ifr_s2;
    logic ifr_last;
  } core_s;

  // Serial clock domain, rising edge.
  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic req_s1;
    logic req_s2;
    logic ack;
    logic [`ADC_HOLD_BITS-1:0] word;
    logic pending;
    link_phase_e phase;
    logic [5:0] bitcnt;
    logic [5:0] len;
    logic [7:0] shin;
    logic rd_data;
    logic cread;
    logic [5:0] ones;
    logic done_tgl;
    logic ifr_tgl;
    logic rd_tgl;
    logic [`ADC_WORD_BITS-1:0] load_word;
  } link_s;

  // Serial clock domain, falling edge.
  typedef struct packed {
    logic [`ADC_WORD_BITS-1:0] out;
    logic seen;
  } shift_s;

endpackage

/* hw/adc_serial_sequencer_control.sv */
// Digital control of a multichannel sigma-delta converter: channel sequencer,
// output coding and the serial register port with its shared ready line.
// Assumes setup inputs and the filter strobe are synchronous to core_clk, and
// that cs_n and din change away from the rising edge of sclk.
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_params.svh"

module adc_serial_sequencer_control (
  // Core clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Conversion setup
  input wire logic unipolar,
  input wire logic burnout_en,
  input wire logic [7:0] channel_enable,
  input wire logic pseudo_mode,
  input wire logic temp_en,
  input wire logic short_en,
  input wire logic append_status_enable,
  input wire logic reference_missing,
  // Modulator and filter
  input wire logic [23:0] filter_word,
  input wire logic filter_valid,
  output logic mod_reset,
  output logic [3:0] channel_sel,
  output logic burnout_src_en,
  output logic burnout_sink_en,
  output logic pseudo_sel,
  // Serial port
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic dout_rdy_n,
  output logic dout_oe
);

  adc_seq_pkg::core_s c;
  adc_seq_pkg::core_s cn;
  adc_seq_pkg::link_s l;
  adc_seq_pkg::link_s ln;
  adc_seq_pkg::shift_s s;
  adc_seq_pkg::shift_s sn;
  logic [9:0] src_en;

  // Next enabled source after cur, wrapping; cur itself if it is the only one.
  function automatic logic [3:0] next_chan(input logic [3:0] cur,
                                           input logic [9:0] en);
    logic [3:0] k;
    logic found;
    k = cur;
    found = 1'b0;
    next_chan = cur;
    for (int i = 0; i < `ADC_NUM_SRC; i++) begin
      k = (k == `ADC_LAST_SRC) ? 4'h0 : k + 4'h1;
      if (en[k] && !found) begin
        next_chan = k;
        found = 1'b1;
      end
    end
  endfunction

  // Serial length of a register; the data register grows by the status byte.
  function automatic logic [5:0] reg_len(input logic [2:0] a, input logic app);
    if (a == `ADC_REG_STATUS || a == `ADC_REG_ID || a == `ADC_REG_GPIO_CTRL) begin
      reg_len = `ADC_LEN_BYTE;
    end else if (a == `ADC_REG_DATA && app) begin
      reg_len = `ADC_LEN_CODE + `ADC_LEN_BYTE;
    end else begin
      reg_len = `ADC_LEN_CODE;
    end
  endfunction

  // The temperature sensor and the short are sources 8 and 9 of the sequence.
  assign src_en = {short_en, temp_en, channel_enable};

  // Core domain: sequencer, output coding, ready flag and word hand-off.
  always_comb begin
    cn = c;
    cn.reference_missing_s1 = reference_missing;
    cn.reference_missing_s2 = c.reference_missing_s1;
    cn.ack_s1 = l.ack;
    cn.ack_s2 = c.ack_s1;
    cn.done_s1 = l.done_tgl;
    cn.done_s2 = c.done_s1;
    cn.done_last = c.done_s2;
    cn.ifr_s1 = l.ifr_tgl;
    cn.ifr_s2 = c.ifr_s1;
    cn.ifr_last = c.ifr_s2;
    cn.mod_reset = 1'b0;
    cn.burnout = burnout_en;
    cn.pseudo = pseudo_mode;
    if (c.done_s2 != c.done_last) begin
      cn.rdy_n = 1'b1;
    end
    // A word moves to the serial side only when the previous one was taken,
    // so the serial side may read the hold register without a race.
    if (c.dirty && c.req == c.ack_s2) begin
      cn.hold = {append_status_enable, c.data};
      cn.req = ~c.req;
      cn.dirty = 1'b0;
    end
    case (c.state)
      adc_seq_pkg::SEQ_IDLE: begin
        if (src_en != `ADC_SRC_NONE) begin
          cn.chan = next_chan(`ADC_LAST_SRC, src_en);
          cn.state = adc_seq_pkg::SEQ_RESET;
        end
      end
      adc_seq_pkg::SEQ_RESET: begin
        cn.mod_reset = 1'b1;
        cn.settle = 3'h0;
        cn.state = (src_en == `ADC_SRC_NONE) ? adc_seq_pkg::SEQ_IDLE
                                             : adc_seq_pkg::SEQ_SETTLE;
      end
      adc_seq_pkg::SEQ_SETTLE: begin
        if (src_en == `ADC_SRC_NONE) begin
          cn.state = adc_seq_pkg::SEQ_IDLE;
        end else if (filter_valid) begin
          if (c.settle == `ADC_SETTLE_WORDS - 3'h1) begin
            if (c.reference_missing_s2) begin
              cn.code = `ADC_CODE_ONES;
            end else if (unipolar) begin
              // Negative readings clamp to zero; full scale reads all ones.
              if (filter_word[23]) begin
                cn.code = `ADC_CODE_ZERO;
              end else if (filter_word == `ADC_CODE_POS_MAX) begin
                cn.code = `ADC_CODE_ONES;
              end else begin
                cn.code = {filter_word[22:0], 1'b0};
              end
            end else begin
              cn.code = filter_word ^ `ADC_CODE_MID;
            end
            cn.rdy_n = 1'b1;
            cn.state = adc_seq_pkg::SEQ_WARN;
          end else begin
            cn.settle = c.settle + 3'h1;
          end
        end
      end
      adc_seq_pkg::SEQ_WARN: begin
        // Status byte: ready, error, missing reference, parity, channel.
        cn.data = {c.code, 1'b0, 1'b0, c.reference_missing_s2, 1'b0, c.chan};
        cn.rdy_n = 1'b0;
        cn.dirty = 1'b1;
        cn.chan = next_chan(c.chan, src_en);
        cn.state = adc_seq_pkg::SEQ_RESET;
      end
      default: begin
        cn.state = adc_seq_pkg::SEQ_IDLE;
      end
    endcase
    if (c.ifr_s2 != c.ifr_last) begin
      cn.state = adc_seq_pkg::SEQ_IDLE;
      cn.chan = `ADC_CHAN_RST;
      cn.settle = 3'h0;
      cn.code = `ADC_CODE_ZERO;
      cn.data = '0;
      cn.rdy_n = `ADC_RDY_N_RST;
      cn.dirty = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      c <= '0;
      c.rdy_n <= `ADC_RDY_N_RST;
    end else begin
      c <= cn;
    end
  end

  // Serial domain, rising edge: samples din, decodes commands, counts bits.
  always_comb begin
    logic [7:0] b;
    logic [2:0] a;
    b = {l.shin[6:0], din};
    a = b[`ADC_COMM_ADDR_HI:`ADC_COMM_ADDR_LO];
    ln = l;
    ln.rst_s1 = rstn;
    ln.rst_s2 = l.rst_s1;
    ln.req_s1 = c.req;
    ln.req_s2 = l.req_s1;
    if (!cs_n) begin
      ln.ones = din ? l.ones + 6'h1 : 6'h0;
      ln.shin = b;
      ln.bitcnt = l.bitcnt + 6'h1;
      case (l.phase)
        adc_seq_pkg::LK_CMD: begin
          if (l.cread) begin
            ln.bitcnt = 6'h0;
            if (l.pending) begin
              ln.phase = adc_seq_pkg::LK_RD;
              ln.rd_tgl = ~l.rd_tgl;
              ln.rd_data = 1'b1;
              ln.len = reg_len(`ADC_REG_DATA, l.word[32]);
              ln.load_word = l.word[31:0];
            end
          end else if (l.bitcnt == `ADC_CMD_LAST_BIT) begin
            ln.bitcnt = 6'h0;
            // A byte with the top bit set is not a command; this also lets
            // a run of ones pass without starting a transfer.
            if (!b[`ADC_COMM_WEN]) begin
              if (b[`ADC_COMM_READ] && b[`ADC_COMM_CREAD] && a == `ADC_REG_DATA) begin
                ln.cread = 1'b1;
              end else if (b[`ADC_COMM_READ]) begin
                ln.phase = adc_seq_pkg::LK_RD;
                ln.rd_tgl = ~l.rd_tgl;
                ln.rd_data = (a == `ADC_REG_DATA);
                ln.len = reg_len(a, l.word[32]);
                if (a == `ADC_REG_DATA) begin
                  ln.load_word = l.word[31:0];
                end else if (a == `ADC_REG_STATUS) begin
                  ln.load_word = {l.word[7:0], 24'h000000};
                end else begin
                  ln.load_word = '0;
                end
              end else begin
                ln.phase = adc_seq_pkg::LK_WR;
                ln.len = reg_len(a, l.word[32]);
              end
            end
          end
        end
        adc_seq_pkg::LK_WR: begin
          if (l.bitcnt == l.len - 6'h1) begin
            ln.phase = adc_seq_pkg::LK_CMD;
            ln.bitcnt = 6'h0;
          end
        end
        adc_seq_pkg::LK_RD: begin
          if (l.cread && l.bitcnt == `ADC_CMD_LAST_BIT && b == `ADC_CMD_CREAD_EXIT) begin
            ln.cread = 1'b0;
          end
          if (l.bitcnt == l.len - 6'h1) begin
            ln.phase = adc_seq_pkg::LK_CMD;
            ln.bitcnt = 6'h0;
            if (l.rd_data) begin
              ln.done_tgl = ~l.done_tgl;
              ln.pending = 1'b0;
            end
          end
        end
        default: begin
          ln.phase = adc_seq_pkg::LK_CMD;
        end
      endcase
    end
    // A new word is never taken in the middle of a read, so a word being
    // shifted out cannot change under the host.
    if (l.req_s2 != l.ack && l.phase != adc_seq_pkg::LK_RD
        && ln.phase != adc_seq_pkg::LK_RD) begin
      ln.word = c.hold;
      ln.ack = l.req_s2;
      ln.pending = 1'b1;
    end
    if (!cs_n && din && l.ones == `ADC_IFRST_ONES - 6'h1) begin
      ln.phase = adc_seq_pkg::LK_CMD;
      ln.bitcnt = 6'h0;
      ln.ones = 6'h0;
      ln.cread = 1'b0;
      ln.pending = 1'b0;
      ln.ifr_tgl = ~l.ifr_tgl;
    end
    if (!l.rst_s2) begin
      ln = '0;
      ln.rst_s1 = rstn;
      ln.rst_s2 = l.rst_s1;
    end
  end

  always_ff @(posedge sclk) begin
    l <= ln;
  end

  // Serial domain, falling edge: loads and shifts the output word. The shift
  // holds while cs_n is high, so a frame-sync falling cs_n shows the MSB.
  always_comb begin
    sn = s;
    if (l.rd_tgl != s.seen) begin
      sn.out = l.load_word;
      sn.seen = l.rd_tgl;
    end else if (!cs_n) begin
      sn.out = {s.out[30:0], 1'b0};
    end
    if (!l.rst_s2) begin
      sn = '0;
    end
  end

  always_ff @(negedge sclk) begin
    s <= sn;
  end

  // The shared line carries data during a read and the ready flag otherwise.
  assign dout_rdy_n = (l.phase == adc_seq_pkg::LK_RD) ? s.out[31] : c.rdy_n;
  assign dout_oe = ~cs_n;
  assign mod_reset = c.mod_reset;
  assign channel_sel = c.chan;
  assign burnout_src_en = c.burnout;
  assign burnout_sink_en = c.burnout;
  assign pseudo_sel = c.pseudo;

endmodule

`default_nettype wire

/* sim/adc_seq_properties.sv */
// Concurrent checks on the converter sequencer control, bound to its top module.
// Assumes setup inputs stay stable while rstn is high.
`timescale 1ns/1ps
`default_nettype none
module adc_seq_checker (
  // Core clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Setup and filter
  input wire logic burnout_en,
  input wire logic pseudo_mode,
  input wire logic [7:0] channel_enable,
  input wire logic temp_en,
  input wire logic short_en,
  input wire logic filter_valid,
  // Observed outputs and select
  input wire logic mod_reset,
  input wire logic [3:0] channel_sel,
  input wire logic burnout_src_en,
  input wire logic burnout_sink_en,
  input wire logic pseudo_sel,
  input wire logic cs_n,
  input wire logic dout_rdy_n,
  input wire logic dout_oe
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic [9:0] src_q;
  logic [3:0] prev_ch;
  logic [3:0] nxt;
  logic [2:0] fv_cnt;
  always_ff @(posedge core_clk) begin
    src_q <= {short_en, temp_en, channel_enable};
    if (mod_reset) prev_ch <= channel_sel;
    // The sequencer already counts a filter word in the cycle of its reset pulse.
    if (!rstn) fv_cnt <= 3'h0;
    else if (mod_reset) fv_cnt <= {2'b00, filter_valid};
    else if (filter_valid && fv_cnt != 3'h7) fv_cnt <= fv_cnt + 3'h1;
  end
  // The nearest enabled id above the current one wins; a lone source repeats.
  always_comb begin
    nxt = prev_ch;
    for (int k = 9; k >= 1; k--) begin
      if (src_q[(32'(prev_ch) + k) % 10]) nxt = 4'((32'(prev_ch) + k) % 10);
    end
  end
  a_burnout_pair: assert property (burnout_src_en == burnout_sink_en)
    else $error("burnout source and sink differ");
  a_burnout_follow: assert property ($past(rstn) |-> burnout_src_en == $past(burnout_en))
    else $error("burnout output does not follow its enable");
  a_pseudo_follow: assert property ($past(rstn) |-> pseudo_sel == $past(pseudo_mode))
    else $error("pairing select does not follow its input");
  a_sel_enabled: assert property (mod_reset |-> src_q[channel_sel])
    else $error("selected source is not enabled");
  a_pulse_single: assert property (mod_reset |=> !mod_reset)
    else $error("modulator reset longer than one cycle");
  a_update_after_four: assert property (filter_valid && fv_cnt == 3'h3 |-> ##[1:3] mod_reset)
    else $error("no channel step after four filter words");
  a_warn_first: assert property (mod_reset && fv_cnt == 3'h4 && cs_n && $past(cs_n, 2)
    |-> $past(dout_rdy_n, 2))
    else $error("ready line not high before the update");
  a_ready_new: assert property (mod_reset && fv_cnt == 3'h4 && cs_n |-> !dout_rdy_n)
    else $error("ready line not low with a new result");
  a_seq_order: assert property (mod_reset && fv_cnt == 3'h4 |-> channel_sel == nxt)
    else $error("next channel out of order");
  a_oe_select: assert property (dout_oe == !cs_n)
    else $error("output enable does not follow select");
  c_update: cover property (mod_reset && fv_cnt == 3'h4);
  c_wrap: cover property (mod_reset && fv_cnt == 3'h4 && channel_sel < prev_ch);
  c_read: cover property (dout_oe && !dout_rdy_n);
endmodule
bind adc_serial_sequencer_control adc_seq_checker u_chk (.core_clk, .rstn, .burnout_en,
  .pseudo_mode, .channel_enable, .temp_en, .short_en, .filter_valid, .mod_reset,
  .channel_sel, .burnout_src_en, .burnout_sink_en, .pseudo_sel, .cs_n, .dout_rdy_n, .dout_oe);
`default_nettype wire

/* sim/serial_host.sv */
// Serial host model in clock-idle-high mode: changes din on falling edges.
// Assumes the device drives its data pin on falling edges while selected.
`timescale 1ns/1ps
`default_nettype none
module serial_host (
  // Serial pins
  output logic sclk,
  output logic cs_n,
  output logic din,
  input wire logic dout,
  input wire logic dout_oe
);
  // Three-wire operation keeps the device selected between transfers.
  logic three_wire = 1'b0;
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din = 1'b0;
  end
  // Clock stands still between frames; din rests low so a continuous read is kept.
  task automatic bits(input logic [39:0] tx, input int n, output logic [39:0] rx);
    rx = '0;
    #3.3;
    cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      sclk = 1'b0;
      din = tx[i];
      #7.5;
      sclk = 1'b1;
      rx = {rx[38:0], dout & dout_oe};
      #7.5;
    end
    cs_n = !three_wire;
    din = 1'b0;
  endtask
  task automatic idle(input int n);
    cs_n = 1'b1;
    repeat (n) begin
      sclk = 1'b0;
      #7.5;
      sclk = 1'b1;
      #7.5;
    end
  endtask
endmodule
`default_nettype wire

/* sim/test_adc_serial_sequencer_control.sv */
// Self-checking bench for the converter sequencer control.
// Assumes the serial host model and the bound checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module test_adc_serial_sequencer_control;
  logic core_clk, rstn, unipolar, burnout_en, pseudo_mode, temp_en, short_en;
  logic append_status_enable, reference_missing, filter_valid, mod_reset;
  logic burnout_src_en, burnout_sink_en, pseudo_sel, sclk, cs_n, din, dout_rdy_n, dout_oe;
  logic [7:0] channel_enable;
  logic [23:0] filter_word, last_word;
  logic [23:0] edge_w [4] = '{24'h000000, 24'h7FFFFF, 24'h800000, 24'hFFFFFF};
  logic [3:0] channel_sel, conv;
  logic [39:0] rx;
  logic [31:0] exp_q [$];
  int mismatches, tests_run, cnt, cycles, w;
  adc_serial_sequencer_control DUT (.core_clk, .rstn, .unipolar, .burnout_en, .channel_enable,
    .pseudo_mode, .temp_en, .short_en, .append_status_enable, .reference_missing, .filter_word,
    .filter_valid, .mod_reset, .channel_sel, .burnout_src_en, .burnout_sink_en, .pseudo_sel,
    .sclk, .cs_n, .din, .dout_rdy_n, .dout_oe);
  serial_host host (.sclk, .cs_n, .din, .dout(dout_rdy_n), .dout_oe);
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  function automatic logic [23:0] coded(input logic [23:0] f);
    if (reference_missing) return 24'hFFFFFF;
    if (!unipolar) return f ^ 24'h800000;
    if (f[23]) return 24'h000000;
    if (f == 24'h7FFFFF) return 24'hFFFFFF;
    return {f[22:0], 1'b0};
  endfunction
  // Reference model: the fourth filter word after a channel start is the result.
  always @(negedge core_clk) begin
    cycles++;
    if (cycles == 80000) begin
      mismatches++;
      finish_test();
    end else if (!rstn) cnt = 0;
    else if (mod_reset) begin
      if (cnt == 4) exp_q.push_back(append_status_enable ?
        {coded(last_word), 2'b00, reference_missing, 1'b0, conv} : {8'h00, coded(last_word)});
      conv = channel_sel;
      cnt = filter_valid ? 1 : 0;
      last_word = filter_word;
    end else if (filter_valid) begin
      cnt++;
      last_word = filter_word;
    end
  end
  initial begin
    filter_valid = 1'b0;
    filter_word = 24'h000000;
    forever begin
      repeat (60) @(posedge core_clk);
      #1;
      filter_valid = 1'b1;
      filter_word = ($urandom % 6 < 4) ? edge_w[$urandom % 4] : 24'($urandom);
      @(posedge core_clk);
      #1;
      filter_valid = 1'b0;
    end
  end
  task automatic wait_rdy;
    int n;
    n = 0;
    repeat (5) @(posedge core_clk);
    #1;
    while (dout_rdy_n !== 1'b0 && n < 1000) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (n == 1000) mismatches++;
  endtask
  task automatic read_data(input logic [7:0] cmd, input int pre);
    host.bits(40'(cmd) << (pre > 0 ? w - 8 : w), pre + (pre > 0 ? w : w + 8), rx);
    check(rx & ((40'h1 << w) - 40'h1), 40'(exp_q[$]));
  endtask
  initial begin
    {rstn, unipolar, burnout_en, pseudo_mode, temp_en, short_en} = 6'h00;
    {append_status_enable, reference_missing, channel_enable} = 10'h001;
    {mismatches, tests_run, cycles, cnt} = '0;
    void'($urandom(4019));
    for (int c = 0; c < 3; c++) begin
      @(posedge core_clk);
      #1;
      rstn = 1'b0;
      {unipolar, burnout_en, pseudo_mode, temp_en, short_en} = 5'($urandom);
      channel_enable = (c == 2) ? 8'h80 : (8'($urandom) | 8'h01);
      append_status_enable = (c != 1);
      reference_missing = (c == 1);
      w = append_status_enable ? 32 : 24;
      fork
        repeat (10) @(posedge core_clk);
        host.idle(6);
      join
      @(posedge core_clk);
      #1;
      rstn = 1'b1;
      // The link leaves reset only after two rising serial edges; these are given here outside a transfer.
      host.idle(3);
      host.three_wire = (c == 1);
      wait_rdy();
      read_data(8'h58, 0);
      repeat (5) @(posedge core_clk);
      #1;
      check(40'(dout_rdy_n), 40'h1);
      read_data(8'h58, 0);
      host.bits(40'(8'h08) << 24, 32, rx);
      host.bits(40'(8'h60) << 8, 16, rx);
      check(40'(rx[7:0]), 40'h0);
      if (append_status_enable) begin
        host.bits(40'(8'h40) << 8, 16, rx);
        check(40'(rx[7:0]), 40'(exp_q[$][7:0]));
      end
      wait_rdy();
      read_data(8'h58, 0);
      host.bits(40'h5C, 8, rx);
      wait_rdy();
      read_data(8'h00, 4);
      wait_rdy();
      read_data(8'h58, 4);
      wait_rdy();
      read_data(8'h58, 0);
    end
    host.bits({40{1'b1}}, 40, rx);
    repeat (10) @(posedge core_clk);
    #1;
    check(40'(dout_rdy_n), 40'h1);
    #500000;
    host.bits(40'(8'h58) << w, w + 8, rx);
    wait_rdy();
    read_data(8'h58, 0);
    finish_test();
  end
endmodule
`default_nettype wire
